// file: hw/boot_bus_ctrl.sv
// Notes on behaviour
// R01 - mode 000: byte boot 32 words, full
// R02 - mode 010: no boot, run external 0
// R03 - mode 100: byte boot 32 words, host
// R04 - mode 101: host port boot, wait pm0
// R05 - byte boot starts at reset release
// R06 - boot clears fields, format 0, count 32
// R07 - boot sets hold, restart at 0
// R08 - host byte dma drives only low bit
// R09 - master holds request while using bus
// R10 - idle bus: grant, float, halt next cycle
// R11 - go mode halts only on external access
// R12 - busy bus: grant after access ends
// R13 - grant may fall between two accesses
// R14 - request gone: release grant, drive, resume
// R15 - arbitration works during boot and reset
// R16 - hung flag when stalled by grant
// R17 - master releases request on hung
// R18 - return clears grant and hung
// R19 - sample mode pins at reset rise
// R20 - hold: stop, clear, restart at 0
// R21 - nonzero count write starts dma
// R22 - reserved modes act as no boot
// R23 - request passes two flip-flops first
//
// The placing of the registers and register access over APB were left to the implementer.
`include "boot_bus_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module boot_bus_ctrl
    import boot_bus_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_reset_n,
    input wire logic [2:0] mode_pins,
    input wire logic bus_request_n,
    input wire logic ext_access_active,
    input wire logic ext_access_pending,
    input wire logic cpu_ready,
    input wire logic dma_word_done,
    input wire logic host_pm0_written,
    output logic bus_grant_n,
    output logic bus_grant_hung_n,
    output logic bus_drive_en,
    output logic upper_addr_drive_en,
    output logic cpu_run,
    output logic cpu_context_clear,
    output logic exec_from_external,
    output logic host_mode,
    output logic byte_dma_go,
    output logic byte_dma_direction,
    output logic [1:0] transfer_format,
    output logic [7:0] byte_mem_page_start,
    output logic [13:0] internal_start_addr,
    output logic [13:0] external_start_addr
);

    ctrl_state_t s_q;
    ctrl_state_t s_d;
    logic br_sync_n;
    logic [13:0] word_transfer_count;
    logic cnt_load;
    logic [13:0] cnt_val;

    request_sync u_req_sync ( // [R23]
        .pclk(pclk),
        .presetn(presetn),
        .async_n(bus_request_n),
        .sync_n(br_sync_n)
    );

    word_counter u_count (
        .pclk(pclk),
        .presetn(presetn),
        .load(cnt_load),
        .load_val(cnt_val),
        .dec(dma_word_done),
        .count_q(word_transfer_count)
    );

    function automatic logic is_mapped(input logic [11:0] a);
        return a == `OFF_CTRL || a == `OFF_DMA_CFG || a == `OFF_DMA_IADDR ||
               a == `OFF_DMA_EADDR || a == `OFF_DMA_COUNT || a == `OFF_STATUS;
    endfunction

    logic setup;
    logic wr;
    logic rel;
    logic byte_boot;

    always_comb begin
        s_d = s_q;
        setup = psel && !penable;
        wr = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
        rel = chip_reset_n && !s_q.chip_rst_n;
        byte_boot = mode_pins == `MODE_BYTE_FULL || mode_pins == `MODE_BYTE_HOST;
        cnt_load = 1'b0;
        cnt_val = pwdata[13:0];
        s_d.chip_rst_n = chip_reset_n;
        s_d.busy = word_transfer_count != 14'h0000;
        s_d.ctx_clear = 1'b0;

        // apb: answer in the first access cycle
        s_d.pready = setup;
        s_d.pslverr = setup && !is_mapped(paddr);
        s_d.prdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            unique case (paddr)
                `OFF_CTRL: s_d.prdata = {30'h0, s_q.hold, s_q.go_mode};
                `OFF_DMA_CFG: s_d.prdata = {21'h0, s_q.page, s_q.fmt, s_q.dir};
                `OFF_DMA_IADDR: s_d.prdata = {18'h0, s_q.iaddr};
                `OFF_DMA_EADDR: s_d.prdata = {18'h0, s_q.eaddr};
                `OFF_DMA_COUNT: s_d.prdata = {18'h0, word_transfer_count};
                `OFF_STATUS: s_d.prdata = {21'h0, s_q.st, s_q.mode, s_q.ext_start,
                    s_q.host_mode, s_q.busy, s_q.hung, s_q.grant, s_q.run};
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                `OFF_CTRL: begin
                    s_d.go_mode = pwdata[`CTRL_GO_BIT];
                    s_d.hold = pwdata[`CTRL_HOLD_BIT];
                end
                `OFF_DMA_CFG: begin
                    s_d.dir = pwdata[`CFG_DIR_BIT];
                    s_d.fmt = pwdata[`CFG_FMT_MSB:`CFG_FMT_LSB];
                    s_d.page = pwdata[`CFG_PAGE_MSB:`CFG_PAGE_LSB];
                end
                `OFF_DMA_IADDR: s_d.iaddr = pwdata[13:0];
                `OFF_DMA_EADDR: s_d.eaddr = pwdata[13:0];
                `OFF_DMA_COUNT: cnt_load = 1'b1; // [R21]
                default: ;
            endcase
        end

        // boot sequencing on the chip reset, apart from the bus logic
        if (!chip_reset_n) begin
            s_d.st = ST_CHIP_RESET;
        end else if (rel) begin
            s_d.mode = mode_pins; // [R19]
            s_d.host_mode = mode_pins[2];
            s_d.ext_start = 1'b0;
            if (byte_boot) begin
                s_d.st = ST_BYTE_BOOT; // [R05] [R01] [R03]
                s_d.dir = `DIR_RST; // [R06]
                s_d.page = `PAGE_RST;
                s_d.iaddr = `ADDR_RST;
                s_d.eaddr = `ADDR_RST;
                s_d.fmt = `FMT_PM24;
                cnt_load = 1'b1;
                cnt_val = `BOOT_WORDS;
                s_d.hold = 1'b1; // [R07]
            end else if (mode_pins == `MODE_HOST_PORT) begin
                s_d.st = ST_HOST_BOOT; // [R04]
                s_d.hold = `HOLD_RST;
            end else begin
                // reserved codes fall back to the no-boot start
                s_d.st = ST_RUN; // [R02] [R22]
                s_d.host_mode = 1'b0;
                s_d.ext_start = 1'b1;
                s_d.hold = `HOLD_RST;
                s_d.ctx_clear = 1'b1;
            end
        end else begin
            unique case (s_q.st)
                ST_BYTE_BOOT: if (s_q.busy && !s_d.busy) s_d.st = ST_RUN;
                ST_HOST_BOOT: if (host_pm0_written) begin
                    s_d.st = ST_RUN; // [R04]
                    s_d.ctx_clear = 1'b1;
                end
                ST_RUN, ST_CHIP_RESET: ;
            endcase
        end
        // a finished held transfer restarts the core at 0
        if (chip_reset_n && s_q.hold && s_q.busy && !s_d.busy) begin
            s_d.ctx_clear = 1'b1; // [R20] [R07]
        end

        // arbitration never looks at chip reset
        if (br_sync_n) begin
            s_d.grant = 1'b0; // [R14] [R18] [R17]
        end else begin
            // request stays asserted while the master owns the bus
            s_d.grant = s_q.grant || !ext_access_active; // [R10] [R12] [R13] [R15] [R09]
        end
        s_d.hung = s_d.grant && cpu_ready && (!s_d.go_mode || ext_access_pending); // [R16]
        s_d.run = s_d.st == ST_RUN && !(s_d.hold && s_d.busy) && // [R20]
                  !(s_d.grant && (!s_d.go_mode || ext_access_pending)); // [R10] [R11]
        s_d.drive_en = !s_d.grant; // [R10] [R14]
        s_d.dma_go = s_d.busy && !s_d.grant && !ext_access_active;
        // host mode byte dma: outside logic builds the upper address
        s_d.upper_addr_en = s_d.drive_en && !(s_d.host_mode && s_d.dma_go); // [R08]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{st: ST_CHIP_RESET, chip_rst_n: 1'b0, mode: 3'h0, host_mode: 1'b0,
                     ext_start: 1'b0, go_mode: `GO_RST, hold: `HOLD_RST, dir: `DIR_RST,
                     fmt: `FMT_PM24, page: `PAGE_RST, iaddr: `ADDR_RST,
                     eaddr: `ADDR_RST, busy: 1'b0, grant: 1'b0, hung: 1'b0,
                     run: 1'b0, ctx_clear: 1'b0, drive_en: 1'b1,
                     upper_addr_en: 1'b1, dma_go: 1'b0, pready: 1'b0,
                     pslverr: 1'b0, prdata: 32'h0000_0000};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign bus_grant_n = !s_q.grant;
    assign bus_grant_hung_n = !s_q.hung;
    assign bus_drive_en = s_q.drive_en;
    assign upper_addr_drive_en = s_q.upper_addr_en;
    assign cpu_run = s_q.run;
    assign cpu_context_clear = s_q.ctx_clear;
    assign exec_from_external = s_q.ext_start;
    assign host_mode = s_q.host_mode;
    assign byte_dma_go = s_q.dma_go;
    assign byte_dma_direction = s_q.dir;
    assign transfer_format = s_q.fmt;
    assign byte_mem_page_start = s_q.page;
    assign internal_start_addr = s_q.iaddr;
    assign external_start_addr = s_q.eaddr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence restart_s;
        cpu_context_clear ##1 !cpu_context_clear;
    endsequence

    sequence byte_boot_entry_s;
        $rose(chip_reset_n) && (mode_pins == `MODE_BYTE_FULL || mode_pins == `MODE_BYTE_HOST);
    endsequence

    grant_on_idle_a: assert property ( // [R10] [R15]
        !br_sync_n && !ext_access_active |=> !bus_grant_n && !bus_drive_en)
        else $error("grant missing after idle request");

    grant_waits_access_a: assert property ( // [R12]
        bus_grant_n && ext_access_active |=> bus_grant_n)
        else $error("grant during external access");

    release_clears_a: assert property ( // [R14] [R18]
        br_sync_n |=> bus_grant_n && bus_grant_hung_n && bus_drive_en)
        else $error("grant or hung kept after release");

    halt_on_grant_a: assert property ( // [R10] [R11]
        // run was decided on the pending flag of the cycle before
        !bus_grant_n && (!s_q.go_mode || $past(ext_access_pending)) |-> !cpu_run)
        else $error("core runs while bus granted");

    hung_needs_grant_a: assert property ( // [R16]
        !bus_grant_hung_n |-> !bus_grant_n)
        else $error("hung without grant");

    req_two_stage_a: assert property ( // [R23]
        $fell(bus_request_n) && bus_grant_n && $past(bus_request_n, 2) |-> bus_grant_n [*3])
        else $error("request reached grant too early");

    boot_defaults_a: assert property ( // [R05] [R06] [R07]
        byte_boot_entry_s |=> word_transfer_count == `BOOT_WORDS && s_q.hold &&
            s_q.st == ST_BYTE_BOOT && !byte_dma_direction && internal_start_addr == 14'h0)
        else $error("byte boot defaults wrong");

    boot_holds_core_a: assert property ( // [R01] [R03]
        s_q.st == ST_BYTE_BOOT |-> !cpu_run)
        else $error("core runs during byte boot");

    held_restart_a: assert property ( // [R20]
        s_q.hold && s_q.busy && word_transfer_count == 14'h0 && chip_reset_n |=> restart_s)
        else $error("no restart after held transfer");

    host_boot_done_a: assert property ( // [R04]
        s_q.st == ST_HOST_BOOT && chip_reset_n && host_pm0_written |=> restart_s)
        else $error("host boot did not restart");

    host_low_bit_a: assert property ( // [R08]
        host_mode && byte_dma_go |-> !upper_addr_drive_en)
        else $error("upper address driven in host dma");

    count_start_a: assert property ( // [R21]
        psel && penable && pwrite && pready && !pslverr && paddr == `OFF_DMA_COUNT &&
            pwdata[13:0] != 14'h0 && chip_reset_n && s_q.chip_rst_n |-> ##2 s_q.busy)
        else $error("count write did not start dma");

endmodule

`default_nettype wire

// file: hw/boot_bus_regs.svh
`ifndef BOOT_BUS_REGS_SVH
`define BOOT_BUS_REGS_SVH

// register byte offsets on the apb slave
`define OFF_CTRL 12'h000
`define OFF_DMA_CFG 12'h004
`define OFF_DMA_IADDR 12'h008
`define OFF_DMA_EADDR 12'h00c
`define OFF_DMA_COUNT 12'h010
`define OFF_STATUS 12'h014

// control register fields
`define CTRL_GO_BIT 0
`define CTRL_HOLD_BIT 1

// byte dma configuration fields
`define CFG_DIR_BIT 0
`define CFG_FMT_LSB 1
`define CFG_FMT_MSB 2
`define CFG_PAGE_LSB 3
`define CFG_PAGE_MSB 10

// reset and boot defaults
`define GO_RST 1'h0
`define HOLD_RST 1'h0
`define DIR_RST 1'h0
`define FMT_PM24 2'h0
`define PAGE_RST 8'h00
`define ADDR_RST 14'h0000
`define BOOT_WORDS 14'h0020

// boot configuration pin codes, ordered {c, b, a}
`define MODE_BYTE_FULL 3'h0
`define MODE_NO_BOOT 3'h2
`define MODE_BYTE_HOST 3'h4
`define MODE_HOST_PORT 3'h5

`endif

// file: hw/boot_bus_pkg.sv
package boot_bus_pkg;

    typedef enum logic [1:0] {
        ST_CHIP_RESET,
        ST_BYTE_BOOT,
        ST_HOST_BOOT,
        ST_RUN
    } boot_state_t;

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_t;

    typedef struct packed {
        logic [13:0] count;
    } count_state_t;

    typedef struct packed {
        boot_state_t st;
        logic chip_rst_n;
        logic [2:0] mode;
        logic host_mode;
        logic ext_start;
        logic go_mode;
        logic hold;
        logic dir;
        logic [1:0] fmt;
        logic [7:0] page;
        logic [13:0] iaddr;
        logic [13:0] eaddr;
        logic busy;
        logic grant;
        logic hung;
        logic run;
        logic ctx_clear;
        logic drive_en;
        logic upper_addr_en;
        logic dma_go;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctrl_state_t;

endpackage

// file: hw/request_sync.sv
`timescale 1ns/1ps
`default_nettype none

module request_sync
    import boot_bus_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_n,
    output logic sync_n
);

    sync_state_t s_q;
    sync_state_t s_d;

    // first stage feeds only the second one
    always_comb begin
        s_d = s_q;
        s_d.meta = async_n;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{meta: 1'b1, stable: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_n = s_q.stable;

endmodule

`default_nettype wire

// file: hw/word_counter.sv
`timescale 1ns/1ps
`default_nettype none

module word_counter
    import boot_bus_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [13:0] load_val,
    input wire logic dec,
    output logic [13:0] count_q
);

    count_state_t s_q;
    count_state_t s_d;

    // a load beats a decrement landing in the same cycle
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.count = load_val;
        end else if (dec && s_q.count != 14'h0000) begin
            s_d.count = s_q.count - 14'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{count: 14'h0000};
        end else begin
            s_q <= s_d;
        end
    end

    assign count_q = s_q.count;

endmodule

`default_nettype wire

// file: verif/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic need_bus,
    input wire logic bus_grant_hung_n,
    output logic bus_request_n
);
    logic backed_off_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_request_n <= 1'b1;
            backed_off_q <= 1'b0;
        end else begin
            // request held while the bus is wanted and not backed off
            bus_request_n <= !(need_bus && !backed_off_q);
            // stalled core seen: hand the bus back until next need
            if (!need_bus) begin
                backed_off_q <= 1'b0;
            end else if (!bus_grant_hung_n && !bus_request_n) begin
                backed_off_q <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// file: verif/testbench.sv
`include "boot_bus_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic chip_reset_n = 1'b0, need_bus = 1'b0;
    logic [2:0] mode_pins = 3'h0;
    logic bus_request_n, ext_access_active = 1'b0, ext_access_pending = 1'b0;
    logic cpu_ready = 1'b0, dma_word_done = 1'b0, host_pm0_written = 1'b0;
    logic bus_grant_n, bus_grant_hung_n, bus_drive_en, upper_addr_drive_en;
    logic cpu_run, cpu_context_clear, exec_from_external, host_mode, byte_dma_go;
    logic byte_dma_direction;
    logic [1:0] transfer_format;
    logic [7:0] byte_mem_page_start;
    logic [13:0] internal_start_addr, external_start_addr;
    int n_mismatch = 0, compares = 0, cyc = 0, n;
    // per mode pin code: {host, exec_external, run, dma_go}
    logic [3:0] rows [8] = '{4'h1, 4'h6, 4'h6, 4'h6, 4'h9, 4'h8, 4'h6, 4'h6};

    boot_bus_ctrl boot_bus_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .chip_reset_n, .mode_pins,
        .bus_request_n, .ext_access_active, .ext_access_pending, .cpu_ready,
        .dma_word_done, .host_pm0_written, .bus_grant_n, .bus_grant_hung_n,
        .bus_drive_en, .upper_addr_drive_en, .cpu_run, .cpu_context_clear,
        .exec_from_external, .host_mode, .byte_dma_go, .byte_dma_direction,
        .transfer_format, .byte_mem_page_start, .internal_start_addr,
        .external_start_addr);

    bus_master_model bus_master_model_inst (.pclk, .presetn, .need_bus,
        .bus_grant_hung_n, .bus_request_n);

    initial forever #4 pclk = ~pclk;

    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 12) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // full reset, then chip reset release with the given pins
    task automatic boot(logic [2:0] m);
        @(posedge pclk);
        presetn <= 1'b0;
        chip_reset_n <= 1'b0;
        mode_pins <= m;
        repeat (3) @(posedge pclk);
        chk("rst_out", {bus_grant_n, bus_drive_en, cpu_run}, 3'h6);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chip_reset_n <= 1'b1;
        repeat (2) @(posedge pclk);
        // pins move after the rise and must be ignored
        mode_pins <= ~m;
        repeat (3) @(posedge pclk);
    endtask

    task automatic wait_restart();
        wait_for(cpu_context_clear, 1'h1);
        chk("ctx", cpu_context_clear, 1'h1);
        @(posedge pclk);
        chk("restart", {cpu_run, cpu_context_clear}, 2'h2);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            boot(i[2:0]);
            apb(1'b0, `OFF_DMA_COUNT, 32'h0);
            chk("host", host_mode, rows[i][3]);
            chk("ext0", exec_from_external, rows[i][2]);
            chk("run", cpu_run, rows[i][1]);
            chk("dma_go", byte_dma_go, rows[i][0]);
            chk("count", rd, rows[i][0] ? 32'h20 : 32'h0);
            if (rows[i][0]) chk("upper", upper_addr_drive_en, !rows[i][3]);
        end
        boot(3'h0);
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk("hold", rd[1], 1'h1);
        chk("fields", {byte_dma_direction, transfer_format, byte_mem_page_start,
            internal_start_addr, external_start_addr[6:0]}, 33'h0);
        chk("eaddr", external_start_addr, 33'h0);
        for (int i = 0; i < 32; i++) begin
            dma_word_done <= 1'b1;
            @(posedge pclk);
            chk("held_off", cpu_run, 1'h0);
        end
        dma_word_done <= 1'b0;
        wait_restart();
        boot(3'h5);
        host_pm0_written <= 1'b1;
        @(posedge pclk);
        host_pm0_written <= 1'b0;
        wait_restart();
        apb(1'b1, `OFF_DMA_CFG, 32'h52f);
        @(posedge pclk);
        chk("cfg", {byte_dma_direction, transfer_format, byte_mem_page_start}, 11'h7a5);
        apb(1'b1, `OFF_DMA_IADDR, 32'hffffffff);
        apb(1'b0, `OFF_DMA_IADDR, 32'h0);
        chk("iaddr", {err, rd}, 33'h3fff);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {err, rd}, 33'h100000000);
        apb(1'b1, `OFF_DMA_COUNT, 32'h5);
        repeat (2) @(posedge pclk);
        chk("count_go", byte_dma_go, 1'h1);
        need_bus <= 1'b1;
        wait_for(bus_grant_n, 1'h0);
        chk("grant_fast", n < 6, 1'h1);
        chk("float", {bus_drive_en, cpu_run, bus_grant_hung_n}, 3'h1);
        repeat (5) @(posedge pclk);
        chk("kept", bus_grant_n, 1'h0);
        need_bus <= 1'b0;
        wait_for(bus_grant_n, 1'h1);
        chk("release", {n < 6, bus_drive_en, cpu_run}, 3'h7);
        ext_access_active <= 1'b1;
        need_bus <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("busy", {bus_grant_n, bus_drive_en}, 2'h3);
        ext_access_active <= 1'b0;
        @(posedge pclk);
        ext_access_active <= 1'b1;
        wait_for(bus_grant_n, 1'h0);
        chk("gap_grant", n < 4, 1'h1);
        ext_access_active <= 1'b0;
        need_bus <= 1'b0;
        wait_for(bus_grant_n, 1'h1);
        cpu_ready <= 1'b1;
        need_bus <= 1'b1;
        wait_for(bus_grant_hung_n, 1'h0);
        chk("hung", {bus_grant_hung_n, bus_grant_n}, 2'h0);
        wait_for(bus_grant_n, 1'h1);
        chk("hung_clr", {bus_grant_hung_n, n < 6}, 2'h3);
        need_bus <= 1'b0;
        cpu_ready <= 1'b0;
        apb(1'b1, `OFF_CTRL, 32'h1);
        need_bus <= 1'b1;
        wait_for(bus_grant_n, 1'h0);
        repeat (2) @(posedge pclk);
        chk("go_runs", {bus_grant_n, cpu_run}, 2'h1);
        ext_access_pending <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("go_halt", cpu_run, 1'h0);
        ext_access_pending <= 1'b0;
        need_bus <= 1'b0;
        wait_for(bus_grant_n, 1'h1);
        apb(1'b1, `OFF_CTRL, 32'h0);
        chip_reset_n <= 1'b0;
        need_bus <= 1'b1;
        wait_for(bus_grant_n, 1'h0);
        chk("rst_grant", {bus_grant_n, cpu_run}, 2'h0);
        need_bus <= 1'b0;
        wait_for(bus_grant_n, 1'h1);
        chk("rst_release", bus_grant_n, 1'h1);
        chip_reset_n <= 1'b1;
        tally_and_finish();
    end
endmodule

`default_nettype wire
